// File: hdl/pss_balance.sv
`timescale 1ns/1ps
`include "pss_map.svh"
module pss_balance import pss_pkg::*; (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // switching cycle and currents
  input wire logic cycle_start_in,
  input wire logic [15:0] cur_in,
  input wire logic [15:0] ref_in,
  input wire logic signed [7:0] offset_in,
  // on-time trim
  output logic signed [9:0] fine_out,
  output logic signed [7:0] step_out
);
  typedef struct packed {
    logic signed [9:0] fine;
    logic signed [13:0] err;
    logic signed [7:0] step;
  } pss_bal_state_type;
  pss_bal_state_type s_q, s_d;
  logic signed [17:0] target;

  // integrate current error, then dither fine trim into coarse steps
  always_comb begin
    logic signed [19:0] want;
    logic signed [19:0] quo;
    want = '0;
    quo = '0;
    s_d = s_q;
    target = $signed({2'b00, ref_in}) + 18'(offset_in);
    if (cycle_start_in) begin
      if ($signed({2'b00, cur_in}) < target && s_q.fine < $signed(10'(`PSS_FINE_MAX))) begin
        s_d.fine = s_q.fine + 10'sd1;
      end else if ($signed({2'b00, cur_in}) > target &&
                   s_q.fine > -$signed(10'(`PSS_FINE_MAX))) begin
        s_d.fine = s_q.fine - 10'sd1;
      end
      want = 20'(s_q.fine) * $signed(20'(`PSS_DITHER_STEP_PS)) + 20'(s_q.err);
      quo = want / $signed(20'(`PSS_BASE_STEP_PS));
      s_d.step = 8'(quo);
      s_d.err = 14'(want - quo * $signed(20'(`PSS_BASE_STEP_PS)));
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign fine_out = s_q.fine;
  assign step_out = s_q.step;

  a_fine_rises: assert property (@(posedge clk_in) disable iff (rst_in)
    (cycle_start_in && $signed({2'b00, cur_in}) < target && s_q.fine < 10'sd100)
      |=> s_q.fine == $past(s_q.fine) + 10'sd1)
    else $error("phase trim did not rise");
  a_err_bounded: assert property (@(posedge clk_in) disable iff (rst_in)
    s_q.err < 14'sd5000 && s_q.err > -14'sd5000)
    else $error("dither residue exceeds base step");
endmodule : pss_balance

// File: hdl/pss_map.svh
// Function
// - pin high: run the full phase count from the regulator configuration.
// - pin low: reduced phase count; pin floating: automatic load-based management.
// - automatic mode compares load with four of the five drop levels (not the first) plus one hysteresis.
// - above 3-phase level plus hysteresis: four phases; above 2-phase: three.
// - lower bands give two, then one phase; lowest band runs discontinuous.
// - during a voltage transition run all phases continuous, resume when settled; done in automatic mode only, pin low keeps the reduced count.
// - feedback below its lower window forces all phases continuous at once; done in automatic mode only, pin low keeps the reduced count.
// - frequency change above its limit forces all phases continuous at once; done in automatic mode only, pin low keeps the reduced count.
// - each phase current trims its on-time toward reference plus offset.
// - on-time trim uses 5 ns steps dithered to 0.08 ns resolution.
// - input divider ratio is scale value over 2 to the tenth.
// - sense configuration bit 10 switches off the thermistor current source.
// - store-all copies the configuration to memory and takes 200 ms.
// - memory reloads at power-on and on restore-all, at least 300 us.
// - with write protection set, memory writes have no effect.
// - bad check at initialisation discards data, cuts power, awaits clear.
// - fault cleared by clear command, clear-fault, or store and restart.
// - low-power mode with enable low disables command access.
// - after reset, configuration loads before regulation may begin.
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH
`define PSS_CLK_PERIOD_NS 4
`define PSS_NS_PER_MS 1000000
`define PSS_NS_PER_US 1000
`define PSS_STORE_TIME_MS 200
`define PSS_RESTORE_TIME_US 300
`define PSS_BASE_STEP_PS 5000
`define PSS_DITHER_STEP_PS 80
`define PSS_FINE_MAX 255
`define PSS_NUM_PHASES 4
`define PSS_CMD_CLEAR_FAULTS 8'h03
`define PSS_CMD_STORE_ALL 8'h15
`define PSS_CMD_RESTORE_ALL 8'h16
`define PSS_CMD_CLEAR_NVM 8'hFF
`define PSS_REG_SENSE_CONFIG 8'h34
`define PSS_REG_LOW_PHASE_COUNT 8'hAA
`define PSS_REG_INPUT_SCALE 8'hC0
`define PSS_REG_TEMP_GAIN_OFFSET 8'hC1
`define PSS_REG_WRITE_PROTECT 8'hDB
`define PSS_REG_REGULATOR_CONFIG 8'hE1
`define PSS_REG_LEVEL_FIRST 8'hE3
`define PSS_REG_LEVEL_LAST 8'hE7
`define PSS_REG_HYSTERESIS 8'hE8
`define PSS_IDX_SENSE 4'h0
`define PSS_IDX_LOW_CNT 4'h1
`define PSS_IDX_SCALE 4'h2
`define PSS_IDX_TEMP 4'h3
`define PSS_IDX_WP 4'h4
`define PSS_IDX_VRCFG 4'h5
`define PSS_IDX_LEVEL_FIRST 4'h6
`define PSS_IDX_DCM 4'hA
`define PSS_IDX_HYS 4'hB
`define PSS_NUM_REGS 12
`define PSS_ADDR_CRC 4'hC
`define PSS_CRC_INIT 16'hFFFF
`define PSS_CRC_POLY 16'h1021
`define PSS_TSRC_DIS_BIT 10
`define PSS_WP_BIT 0
`define PSS_VIN_SHIFT 10
`define PSS_MAX_PHASES 3'h4
`define PSS_ONE_PHASE 3'h1
`endif

// File: hdl/pss_phase_ctrl.sv
`timescale 1ns/1ps
`include "pss_map.svh"
module pss_phase_ctrl import pss_pkg::*; #(
  parameter int STORE_CYCLES = `PSS_STORE_TIME_MS * `PSS_NS_PER_MS / `PSS_CLK_PERIOD_NS,
  parameter int RESTORE_CYCLES =
    (`PSS_RESTORE_TIME_US * `PSS_NS_PER_US + `PSS_CLK_PERIOD_NS - 1) / `PSS_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // asynchronous pins
  input wire logic phase_select_high_in,
  input wire logic phase_select_low_in,
  input wire logic feedback_low_in,
  input wire logic enable_in,
  // regulator status
  input wire logic low_power_mode_in,
  input wire logic dynamic_voltage_transition_active_in,
  input wire logic cycle_start_in,
  input wire logic [15:0] load_current_in,
  input wire logic [15:0] freq_change_in,
  input wire logic [15:0] freq_limit_in,
  input wire logic [11:0] vin_sense_in,
  // current balance
  input wire logic [`PSS_NUM_PHASES-1:0][15:0] phase_current_in,
  input wire logic [15:0] current_ref_in,
  input wire logic [`PSS_NUM_PHASES-1:0][7:0] phase_offset_in,
  output logic [`PSS_NUM_PHASES-1:0][9:0] trim_fine_out,
  output logic [`PSS_NUM_PHASES-1:0][7:0] trim_step_out,
  // command port
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] cmd_wdata_in,
  output logic cmd_ack_out,
  output logic cmd_nak_out,
  output logic [15:0] cmd_rdata_out,
  // non-volatile memory
  output logic nvm_rd_out,
  output logic nvm_wr_out,
  output logic [3:0] nvm_addr_out,
  output logic [15:0] nvm_wdata_out,
  input wire logic [15:0] nvm_rdata_in,
  // regulator control
  output logic [2:0] phase_count_out,
  output logic ccm_out,
  output logic power_enable_out,
  output logic busy_out,
  output logic nvm_fault_out,
  output logic thermistor_source_disable_out,
  output logic [15:0] input_voltage_out,
  output logic [15:0] temp_gain_offset_out
);
  pss_main_state_type s_q, s_d;
  logic [3:0] pins_s;
  logic sel_high, sel_low, fb_low, en_s;
  logic auto_mode, comm_ok, busy, force_full, reg_hit;
  logic [3:0] reg_idx;
  logic [2:0] full_cnt, low_cnt;
  logic [16:0] up_lvl;
  pss_word_type dn_lvl;

  // -------------------------------------------------------------------------
  // pin synchronisers and per-phase balance loops
  // -------------------------------------------------------------------------
  pss_sync #(.WIDTH(4)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in({phase_select_high_in, phase_select_low_in, feedback_low_in, enable_in}),
    .q_out(pins_s)
  );
  assign {sel_high, sel_low, fb_low, en_s} = pins_s;

  generate
    for (genvar i = 0; i < `PSS_NUM_PHASES; i++) begin : g_bal
      pss_balance u_bal (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .cycle_start_in(cycle_start_in),
        .cur_in(phase_current_in[i]),
        .ref_in(current_ref_in),
        .offset_in($signed(phase_offset_in[i])),
        .fine_out(trim_fine_out[i]),
        .step_out(trim_step_out[i])
      );
    end
  endgenerate

  // crc-16 over one word, msb first
  function automatic pss_word_type pss_crc_step(pss_word_type c, pss_word_type d);
    pss_word_type r;
    r = c;
    for (int b = 15; b >= 0; b--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[b]) ? `PSS_CRC_POLY : 16'h0000);
    end
    return r;
  endfunction : pss_crc_step

  // -------------------------------------------------------------------------
  // decode and derived settings
  // -------------------------------------------------------------------------
  always_comb begin
    reg_hit = 1'b1;
    reg_idx = `PSS_IDX_SENSE;
    if (cmd_code_in >= `PSS_REG_LEVEL_FIRST && cmd_code_in <= `PSS_REG_LEVEL_LAST) begin
      reg_idx = `PSS_IDX_LEVEL_FIRST + 4'(cmd_code_in - `PSS_REG_LEVEL_FIRST);
    end else begin
      unique case (cmd_code_in)
        `PSS_REG_SENSE_CONFIG: reg_idx = `PSS_IDX_SENSE;
        `PSS_REG_LOW_PHASE_COUNT: reg_idx = `PSS_IDX_LOW_CNT;
        `PSS_REG_INPUT_SCALE: reg_idx = `PSS_IDX_SCALE;
        `PSS_REG_TEMP_GAIN_OFFSET: reg_idx = `PSS_IDX_TEMP;
        `PSS_REG_WRITE_PROTECT: reg_idx = `PSS_IDX_WP;
        `PSS_REG_REGULATOR_CONFIG: reg_idx = `PSS_IDX_VRCFG;
        `PSS_REG_HYSTERESIS: reg_idx = `PSS_IDX_HYS;
        default: reg_hit = 1'b0;
      endcase
    end
  end

  // phase counts clamped to 1..4; zero or out of range means full, except a zero low count means one
  assign full_cnt = (s_q.regs[`PSS_IDX_VRCFG][2:0] == 3'h0 ||
                     s_q.regs[`PSS_IDX_VRCFG][2:0] > `PSS_MAX_PHASES) ?
                    `PSS_MAX_PHASES : s_q.regs[`PSS_IDX_VRCFG][2:0];
  assign low_cnt = (s_q.regs[`PSS_IDX_LOW_CNT][2:0] == 3'h0) ? `PSS_ONE_PHASE :
                   (s_q.regs[`PSS_IDX_LOW_CNT][2:0] > full_cnt) ? full_cnt :
                   s_q.regs[`PSS_IDX_LOW_CNT][2:0];
  assign auto_mode = !sel_high && !sel_low;
  assign force_full = dynamic_voltage_transition_active_in || fb_low || (freq_change_in > freq_limit_in);
  // drop level above and below the present state
  assign up_lvl = {1'b0, s_q.regs[`PSS_IDX_DCM - {1'b0, s_q.aps}]} +
                  {1'b0, s_q.regs[`PSS_IDX_HYS]};
  assign dn_lvl = s_q.regs[`PSS_IDX_HYS - {1'b0, s_q.aps}];
  assign comm_ok = !(low_power_mode_in && !en_s);
  assign busy = s_q.st == PSS_READ || s_q.st == PSS_READ_WAIT ||
                s_q.st == PSS_WRITE || s_q.st == PSS_WRITE_WAIT;

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  always_comb begin
    logic start_rd;
    logic start_wr;
    start_rd = 1'b0;
    start_wr = 1'b0;
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.nak = 1'b0;
    s_d.nvm_rd = 1'b0;
    s_d.nvm_wr = 1'b0;
    s_d.cnt = s_q.cnt + 32'h0000_0001;

    // memory sequencer
    unique case (s_q.st)
      PSS_WAIT_EN: begin
        if (!low_power_mode_in || en_s) begin
          start_rd = 1'b1;
        end
      end
      PSS_READ: begin
        if (s_q.ph == 2'h0) begin
          s_d.nvm_rd = 1'b1;
          s_d.nvm_addr = s_q.addr;
          s_d.ph = 2'h1;
        end else if (s_q.ph == 2'h1) begin
          s_d.ph = 2'h2;
        end else begin
          s_d.ph = 2'h0;
          if (s_q.addr == `PSS_ADDR_CRC) begin
            if (s_q.pass) begin
              s_d.st = PSS_READ_WAIT;
            end else if (nvm_rdata_in == s_q.crc) begin
              s_d.pass = 1'b1;
              s_d.addr = 4'h0;
            end else if (!s_q.booted) begin
              // bad check at start: discard and hold fault
              s_d.st = PSS_FAULT;
              s_d.fault = 1'b1;
              s_d.run = 1'b0;
            end else begin
              s_d.st = PSS_IDLE;
            end
          end else begin
            s_d.crc = pss_crc_step(s_q.crc, nvm_rdata_in);
            if (s_q.pass) begin
              s_d.regs[s_q.addr] = nvm_rdata_in;
            end
            s_d.addr = s_q.addr + 4'h1;
          end
        end
      end
      PSS_READ_WAIT: begin
        if (s_q.cnt >= 32'(RESTORE_CYCLES - 1)) begin
          s_d.st = PSS_IDLE;
          if (!s_q.booted) begin
            s_d.booted = 1'b1;
            s_d.run = 1'b1;
          end
        end
      end
      PSS_IDLE: begin
        if (s_q.pend_store) begin
          s_d.pend_store = 1'b0;
          start_wr = 1'b1;
        end else if (s_q.pend_restore) begin
          s_d.pend_restore = 1'b0;
          start_rd = 1'b1;
        end
      end
      PSS_WRITE: begin
        if (s_q.regs[`PSS_IDX_WP][`PSS_WP_BIT]) begin
          s_d.st = s_q.fault ? PSS_FAULT : PSS_IDLE;
        end else begin
          s_d.nvm_wr = 1'b1;
          s_d.nvm_addr = s_q.addr;
          if (s_q.addr == `PSS_ADDR_CRC) begin
            s_d.wdata = s_q.crc;
            s_d.st = PSS_WRITE_WAIT;
          end else begin
            s_d.wdata = s_q.regs[s_q.addr];
            s_d.crc = pss_crc_step(s_q.crc, s_q.regs[s_q.addr]);
            s_d.addr = s_q.addr + 4'h1;
          end
        end
      end
      PSS_WRITE_WAIT: begin
        if (s_q.cnt >= 32'(STORE_CYCLES - 1)) begin
          s_d.st = s_q.fault ? PSS_FAULT : PSS_IDLE;
        end
      end
      PSS_FAULT: begin
        // store allowed in fault, restart then reloads
        if (s_q.pend_store) begin
          s_d.pend_store = 1'b0;
          start_wr = 1'b1;
        end
      end
      default: s_d.st = PSS_IDLE;
    endcase

    // command port, after the sequencer so a new request wins
    if (cmd_valid_in && comm_ok) begin
      if (reg_hit) begin
        s_d.ack = 1'b1;
        if (cmd_write_in) begin
          s_d.regs[reg_idx] = cmd_wdata_in;
        end else begin
          s_d.rdata = s_q.regs[reg_idx];
        end
      end else if (cmd_write_in && cmd_code_in == `PSS_CMD_STORE_ALL) begin
        s_d.ack = 1'b1;
        s_d.pend_store = 1'b1;
      end else if (cmd_write_in && cmd_code_in == `PSS_CMD_RESTORE_ALL) begin
        s_d.ack = 1'b1;
        s_d.pend_restore = 1'b1;
      end else if (cmd_write_in && (cmd_code_in == `PSS_CMD_CLEAR_NVM ||
                                    cmd_code_in == `PSS_CMD_CLEAR_FAULTS)) begin
        s_d.ack = 1'b1;
        // clear fault and start again from memory
        if (s_q.st == PSS_FAULT) begin
          s_d.fault = 1'b0;
          s_d.booted = 1'b0;
          start_rd = 1'b1;
        end
      end else begin
        s_d.nak = 1'b1;
      end
    end

    // operation launch
    if (start_rd) begin
      s_d.st = PSS_READ;
    end else if (start_wr) begin
      s_d.st = PSS_WRITE;
    end
    if (start_rd || start_wr) begin
      s_d.addr = 4'h0;
      s_d.ph = 2'h0;
      s_d.pass = 1'b0;
      s_d.crc = `PSS_CRC_INIT;
      s_d.cnt = 32'h0000_0000;
    end

    // automatic power state
    if (!auto_mode || force_full) begin
      s_d.aps = full_cnt;
    end else if (s_q.aps > full_cnt) begin
      s_d.aps = full_cnt;
    end else if (cycle_start_in) begin
      // change only at a cycle boundary
      // step up past level plus hysteresis, down at level
      if (s_q.aps < full_cnt && {1'b0, load_current_in} > up_lvl) begin
        s_d.aps = s_q.aps + 3'h1;
      end else if (s_q.aps != 3'h0 && load_current_in <= dn_lvl) begin
        s_d.aps = s_q.aps - 3'h1;
      end
    end

    // phase count and conduction mode
    if (sel_high) begin
      s_d.phases = full_cnt;
      s_d.ccm = 1'b1;
    end else if (sel_low) begin
      s_d.phases = low_cnt;
      s_d.ccm = 1'b1;
    end else begin
      s_d.phases = (s_d.aps == 3'h0) ? `PSS_ONE_PHASE : s_d.aps;
      s_d.ccm = s_d.aps != 3'h0;
    end

    // input voltage from sense and divider ratio
    if (s_q.regs[`PSS_IDX_SCALE] == 16'h0000) begin
      s_d.vin = 16'hFFFF;
    end else begin
      s_d.vin = (({10'h000, vin_sense_in} << `PSS_VIN_SHIFT) / s_q.regs[`PSS_IDX_SCALE]) >
                22'h00FFFF ? 16'hFFFF :
                16'(({10'h000, vin_sense_in} << `PSS_VIN_SHIFT) / s_q.regs[`PSS_IDX_SCALE]);
    end

    // power only after a good load
    s_d.pwr = s_q.run && !s_q.fault && en_s;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // -------------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------------
  assign cmd_ack_out = s_q.ack;
  assign cmd_nak_out = s_q.nak;
  assign cmd_rdata_out = s_q.rdata;
  assign nvm_rd_out = s_q.nvm_rd;
  assign nvm_wr_out = s_q.nvm_wr;
  assign nvm_addr_out = s_q.nvm_addr;
  assign nvm_wdata_out = s_q.wdata;
  assign phase_count_out = s_q.phases;
  assign ccm_out = s_q.ccm;
  assign power_enable_out = s_q.pwr;
  assign busy_out = busy;
  assign nvm_fault_out = s_q.fault;
  assign thermistor_source_disable_out = s_q.regs[`PSS_IDX_SENSE][`PSS_TSRC_DIS_BIT];
  assign input_voltage_out = s_q.vin;
  assign temp_gain_offset_out = s_q.regs[`PSS_IDX_TEMP];

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  a_high_full: assert property (@(posedge clk_in) disable iff (rst_in)
    sel_high |=> phase_count_out == $past(full_cnt) && ccm_out)
    else $error("pin high did not give full count");
  a_low_count: assert property (@(posedge clk_in) disable iff (rst_in)
    (sel_low && !sel_high) |=> phase_count_out == $past(low_cnt) && ccm_out)
    else $error("pin low did not give low count");
  a_trip_full: assert property (@(posedge clk_in) disable iff (rst_in)
    (auto_mode && fb_low) |=> phase_count_out == $past(full_cnt) && ccm_out)
    else $error("window trip did not force full phases");
  a_freq_full: assert property (@(posedge clk_in) disable iff (rst_in)
    (auto_mode && freq_change_in > freq_limit_in) |=> phase_count_out == $past(full_cnt))
    else $error("frequency trip did not force full phases");
  a_dynamic_voltage_transition_ccm: assert property (@(posedge clk_in) disable iff (rst_in)
    (auto_mode && dynamic_voltage_transition_active_in) |=> ccm_out)
    else $error("transition left discontinuous mode on");
  a_dcm_one: assert property (@(posedge clk_in) disable iff (rst_in)
    (!ccm_out && !$past(rst_in)) |-> phase_count_out == `PSS_ONE_PHASE)
    else $error("discontinuous mode with more than one phase");
  a_shed_edge: assert property (@(posedge clk_in) disable iff (rst_in)
    (auto_mode && !force_full && !cycle_start_in && s_q.aps <= full_cnt)
      |=> s_q.aps == $past(s_q.aps))
    else $error("power state changed between cycles");
  a_tsrc_write: assert property (@(posedge clk_in) disable iff (rst_in)
    (cmd_valid_in && comm_ok && cmd_write_in && cmd_code_in == `PSS_REG_SENSE_CONFIG)
      |=> thermistor_source_disable_out == $past(cmd_wdata_in[`PSS_TSRC_DIS_BIT]))
    else $error("thermistor source bit not applied");
  a_wp_blocks: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(s_q.regs[`PSS_IDX_WP][`PSS_WP_BIT]) |-> !nvm_wr_out)
    else $error("memory written while protected");
  a_fault_nopwr: assert property (@(posedge clk_in) disable iff (rst_in)
    nvm_fault_out |=> !power_enable_out)
    else $error("power on during memory fault");
  a_boot_nopwr: assert property (@(posedge clk_in) disable iff (rst_in)
    !s_q.run |=> !power_enable_out)
    else $error("power before configuration load");
  a_comm_off: assert property (@(posedge clk_in) disable iff (rst_in)
    (low_power_mode_in && !en_s && cmd_valid_in) |=> !cmd_ack_out && !cmd_nak_out)
    else $error("command answered in low-power standby");
  a_busy_store: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_q.st == PSS_WRITE_WAIT) |-> busy_out ##1 (busy_out || s_q.st != PSS_READ))
    else $error("busy not shown during store");
endmodule : pss_phase_ctrl

// File: hdl/pss_pkg.sv
package pss_pkg;
  typedef logic [15:0] pss_word_type;
  typedef enum logic [2:0] {
    PSS_WAIT_EN, PSS_READ, PSS_READ_WAIT, PSS_IDLE, PSS_WRITE, PSS_WRITE_WAIT, PSS_FAULT
  } pss_nvm_state_type;
  typedef struct packed {
    pss_nvm_state_type st;
    pss_word_type [11:0] regs;
    logic [3:0] addr;
    logic [1:0] ph;
    logic pass;
    logic booted;
    logic run;
    logic fault;
    pss_word_type crc;
    logic [31:0] cnt;
    logic pend_store;
    logic pend_restore;
    logic [2:0] aps;
    logic [2:0] phases;
    logic ccm;
    logic pwr;
    pss_word_type rdata;
    logic ack;
    logic nak;
    pss_word_type vin;
    logic nvm_rd;
    logic nvm_wr;
    logic [3:0] nvm_addr;
    pss_word_type wdata;
  } pss_main_state_type;
endpackage : pss_pkg

// File: hdl/pss_sync.sv
`timescale 1ns/1ps
module pss_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // asynchronous levels and their synchronised copies
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } pss_sync_state_type;
  pss_sync_state_type s_q, s_d;

  // two-stage chain, only the second stage is read
  always_comb begin
    s_d = s_q;
    s_d.s1 = d_in;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_out = s_q.s2;
endmodule : pss_sync

// File: test/pss_nvm_model.sv
`timescale 1ns/1ps
module pss_nvm_model (
  // clock
  input wire logic clk_in,
  // memory port from the controller
  input wire logic nvm_rd_in,
  input wire logic nvm_wr_in,
  input wire logic [3:0] nvm_addr_in,
  input wire logic [15:0] nvm_wdata_in,
  output logic [15:0] nvm_rdata_out = 16'h0000
);
  // blank memory, so its check word is wrong at first boot
  logic [15:0] mem_q [0:15] = '{default: 16'h0000};
  always @(posedge clk_in) begin
    if (nvm_wr_in) mem_q[nvm_addr_in] <= nvm_wdata_in;
    if (nvm_rd_in) nvm_rdata_out <= mem_q[nvm_addr_in];
    else nvm_rdata_out <= ~nvm_rdata_out; // no stale word when idle
  end
endmodule : pss_nvm_model

// File: test/tb_pss_phase_ctrl.sv
`timescale 1ns/1ps
`include "pss_map.svh"
module tb_pss_phase_ctrl;
  logic clk_in = 0, rst_in = 1, phase_select_high_in = 0, phase_select_low_in = 0;
  logic feedback_low_in = 0, enable_in = 1, low_power_mode_in = 0, dynamic_voltage_transition_active_in = 0;
  logic cycle_start_in = 0, cmd_valid_in = 0, cmd_write_in = 0;
  logic [7:0] cmd_code_in = 0;
  logic [15:0] cmd_wdata_in = 0, load_current_in = 0, freq_change_in = 0;
  logic [15:0] freq_limit_in = 16'hFFFF, current_ref_in = 0, nvm_rdata_in, scale;
  logic [11:0] vin_sense_in = 0;
  logic [3:0][15:0] phase_current_in = '0;
  logic [3:0][7:0] phase_offset_in = '0, trim_step_out;
  logic [3:0][9:0] trim_fine_out;
  logic cmd_ack_out, cmd_nak_out, nvm_rd_out, nvm_wr_out, ccm_out, power_enable_out;
  logic busy_out, nvm_fault_out, thermistor_source_disable_out;
  logic [15:0] cmd_rdata_out, nvm_wdata_out, input_voltage_out, temp_gain_offset_out;
  logic [3:0] nvm_addr_out;
  logic [2:0] phase_count_out;
  int fails = 0, check_count = 0, cyc = 0, seed = 32'h4998;
  pss_phase_ctrl #(.STORE_CYCLES(40), .RESTORE_CYCLES(60)) pss_phase_ctrl_inst (
    .*);
  pss_nvm_model pss_nvm_model_inst (.clk_in(clk_in), .nvm_rd_in(nvm_rd_out),
    .nvm_wr_in(nvm_wr_out), .nvm_addr_in(nvm_addr_out), .nvm_wdata_in(nvm_wdata_out),
    .nvm_rdata_out(nvm_rdata_in));
  // expected input voltage with saturation
  function automatic logic [15:0] exp_vin(input logic [11:0] v, input logic [15:0] s);
    logic [31:0] r;
    r = (s == 0) ? 32'hFFFF : ({20'h0, v} << 10) / s;
    return (r > 32'hFFFF) ? 16'hFFFF : r[15:0];
  endfunction : exp_vin
  // expected fine trim after six cycle boundaries
  function automatic logic [15:0] exp_fine(input logic [15:0] c, input logic [15:0] r);
    return (c < r) ? 16'h0006 : (c > r) ? 16'h03FA : 16'h0000;
  endfunction : exp_fine
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(negedge clk_in);
    {cmd_valid_in, cmd_write_in, cmd_code_in, cmd_wdata_in} = {1'b1, w, c, d};
    @(negedge clk_in);
    chk(cmd_ack_out, 1);
    cmd_valid_in = 0;
  endtask : cmd
  task automatic wait_idle;
    repeat (4) @(negedge clk_in);
    while (busy_out !== 1'b0) @(negedge clk_in);
  endtask : wait_idle
  task automatic pulses(input int n);
    repeat (n) begin
      @(negedge clk_in) cycle_start_in = 1;
      @(negedge clk_in) cycle_start_in = 0;
    end
  endtask : pulses
  task automatic test_done;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  // clock, 4 ns period
  initial forever #2 clk_in = ~clk_in;
  // hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      test_done;
    end
  end
  // main sequence
  initial begin
    repeat (3) @(negedge clk_in);
    rst_in = 0;
    phase_current_in = {$random(seed), $random(seed)};
    current_ref_in = 16'($random(seed));
    scale = 16'h0100 + 16'($random(seed) & 32'h3FF);
    wait_idle;
    chk(nvm_fault_out, 1);
    chk(power_enable_out, 0);
    cmd(1, `PSS_REG_REGULATOR_CONFIG, 16'h0004);
    cmd(1, `PSS_REG_LOW_PHASE_COUNT, 16'h0002);
    cmd(1, `PSS_REG_INPUT_SCALE, scale);
    cmd(1, `PSS_REG_SENSE_CONFIG, 16'h0400);
    cmd(1, `PSS_CMD_STORE_ALL, 16'h0000);
    @(negedge clk_in);
    chk(busy_out, 1);
    wait_idle;
    cmd(1, `PSS_CMD_CLEAR_NVM, 16'h0000);
    wait_idle;
    chk(nvm_fault_out, 0);
    @(negedge clk_in);
    chk(power_enable_out, 1);
    phase_select_high_in = 1;
    repeat (5) @(negedge clk_in);
    chk(phase_count_out, 4);
    {phase_select_high_in, phase_select_low_in} = 2'b01;
    repeat (5) @(negedge clk_in);
    chk(phase_count_out, 2);
    chk(thermistor_source_disable_out, 1);
    vin_sense_in = 12'($random(seed));
    repeat (3) @(negedge clk_in);
    chk(input_voltage_out, exp_vin(vin_sense_in, scale));
    cmd(1, `PSS_REG_WRITE_PROTECT, 16'h0001);
    cmd(1, `PSS_REG_LOW_PHASE_COUNT, 16'h0003);
    cmd(1, `PSS_CMD_STORE_ALL, 16'h0000);
    wait_idle;
    cmd(1, `PSS_CMD_RESTORE_ALL, 16'h0000);
    wait_idle;
    cmd(0, `PSS_REG_LOW_PHASE_COUNT, 16'h0000);
    chk(cmd_rdata_out, 16'h0002);
    phase_select_low_in = 0;
    pulses(6);
    chk({ccm_out, phase_count_out}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      chk(trim_fine_out[i], exp_fine(phase_current_in[i], current_ref_in));
      chk(trim_step_out[i], 16'h0000);
    end
    feedback_low_in = 1;
    repeat (5) @(negedge clk_in);
    chk({ccm_out, phase_count_out}, 16'h000C);
    feedback_low_in = 0;
    pulses(6);
    chk({ccm_out, phase_count_out}, 16'h0001);
    dynamic_voltage_transition_active_in = 1;
    repeat (2) @(negedge clk_in);
    chk({ccm_out, phase_count_out}, 16'h000C);
    dynamic_voltage_transition_active_in = 0;
    freq_limit_in = 16'h00FF;
    pulses(6);
    chk({ccm_out, phase_count_out}, 16'h0001);
    freq_change_in = 16'h0100;
    repeat (2) @(negedge clk_in);
    chk({ccm_out, phase_count_out}, 16'h000C);
    cmd(1, `PSS_REG_TEMP_GAIN_OFFSET, 16'($random(seed)));
    chk(temp_gain_offset_out, cmd_wdata_in);
    @(negedge clk_in) {cmd_valid_in, cmd_write_in, cmd_code_in} = {2'b10, 8'h01};
    @(negedge clk_in) chk({cmd_ack_out, cmd_nak_out}, 16'h0001);
    {low_power_mode_in, enable_in} = 2'b10;
    repeat (4) @(negedge clk_in);
    chk({cmd_ack_out, cmd_nak_out}, 16'h0000);
    cmd_valid_in = 0;
    test_done;
  end
endmodule : tb_pss_phase_ctrl
